//--- inc/opdec_pkg.sv
// Purpose: Shared constants and types for the opcode decoder
// Assumes: 8-bit opcode bytes, fixed instruction encodings
// Notes:   Cycle counts are processor clock states per instruction
package opdec_pkg;

    localparam int unsigned BYTE_W = 8;

    // Register field codes
    localparam logic [2:0] REG_B   = 3'h0;
    localparam logic [2:0] REG_C   = 3'h1;
    localparam logic [2:0] REG_D   = 3'h2;
    localparam logic [2:0] REG_E   = 3'h3;
    localparam logic [2:0] REG_H   = 3'h4;
    localparam logic [2:0] REG_L   = 3'h5;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_A   = 3'h7;

    // Register pair codes
    localparam logic [1:0] PAIR_BC = 2'h0;
    localparam logic [1:0] PAIR_DE = 2'h1;
    localparam logic [1:0] PAIR_HL = 2'h2;
    localparam logic [1:0] PAIR_SP = 2'h3;

    // Fixed opcodes
    localparam logic [7:0] OPC_HALT   = 8'h76;
    localparam logic [7:0] OPC_PUSH_B = 8'hC5;

    // Cycle counts
    localparam logic [4:0] CYC_4  = 5'h04;
    localparam logic [4:0] CYC_5  = 5'h05;
    localparam logic [4:0] CYC_7  = 5'h07;
    localparam logic [4:0] CYC_10 = 5'h0A;
    localparam logic [4:0] CYC_11 = 5'h0B;

    // Reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [1:0] RST_COUNT = 2'h0;

    typedef enum logic [2:0] {
        ALU_ADD = 3'h0,
        ALU_ADC = 3'h1,
        ALU_SUB = 3'h2,
        ALU_SBB = 3'h3,
        ALU_AND = 3'h4,
        ALU_XOR = 3'h5,
        ALU_OR  = 3'h6,
        ALU_CMP = 3'h7
    } alu_op_t;

    typedef enum logic [2:0] {
        CC_NZ = 3'h0,
        CC_Z  = 3'h1,
        CC_NC = 3'h2,
        CC_C  = 3'h3,
        CC_PO = 3'h4,
        CC_PE = 3'h5,
        CC_P  = 3'h6,
        CC_M  = 3'h7
    } cond_t;

    typedef enum logic [3:0] {
        CLS_UNKNOWN           = 4'h0,
        CLS_COPY_REGISTER     = 4'h1,
        CLS_HALT_INSTR        = 4'h2,
        CLS_LOAD_IMM_BYTE     = 4'h3,
        CLS_INCREMENT_REG     = 4'h4,
        CLS_DECREMENT_REG     = 4'h5,
        CLS_ALU_ACCUMULATOR   = 4'h6,
        CLS_ALU_IMMEDIATE     = 4'h7,
        CLS_COND_RETURN       = 4'h8,
        CLS_LOAD_PAIR_IMM     = 4'h9,
        CLS_PUSH_PAIR         = 4'hA,
        CLS_JUMP_CALL_DIRECT  = 4'hB,
        CLS_IO                = 4'hC,
        CLS_OTHER_ONE_BYTE    = 4'hD
    } op_class_t;

    // One-hot fetch states
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b001,
        ST_BYTE2  = 3'b010,
        ST_BYTE3  = 3'b100
    } fetch_st_t;

endpackage

//--- src/opcode_classifier.sv
// Purpose: Combinational opcode classification and cycle count
// Assumes: Opcode byte presented in logic-one-is-high form
// Notes:   Unlisted opcodes report length one and class other-one-byte
`timescale 1ns/100ps
`default_nettype none
module opcode_classifier
    import opdec_pkg::*;
(
    input  wire logic [7:0] opcode_i,
    output op_class_t       op_class_o,
    output logic [1:0]      length_o,
    output logic [4:0]      cycles_o,
    output logic [4:0]      cycles_alt_o,
    output logic [2:0]      dest_reg_field_o,
    output logic [2:0]      src_reg_field_o,
    output logic [1:0]      pair_o
);
    logic [2:0] dst;
    logic [2:0] src;

    assign dst              = opcode_i[5:3];
    assign src              = opcode_i[2:0];
    assign dest_reg_field_o = dst;
    assign src_reg_field_o  = src;
    assign pair_o           = opcode_i[5:4];

    always_comb
    begin
        op_class_o   = CLS_OTHER_ONE_BYTE;
        length_o     = 2'd1;
        cycles_o     = CYC_4;
        cycles_alt_o = CYC_4;
        unique casez (opcode_i)
            8'b01??_????:
            begin
                op_class_o = CLS_COPY_REGISTER;
                cycles_o   = (dst == REG_MEM || src == REG_MEM) ? CYC_7
                                                                 : CYC_5;
                // halt replaces copy
                // Folded in here so case items stay disjoint
                if (opcode_i == OPC_HALT)
                    op_class_o = CLS_HALT_INSTR;
                cycles_alt_o = cycles_o;
            end
            8'b00??_?110:
            begin
                op_class_o   = CLS_LOAD_IMM_BYTE;
                length_o     = 2'd2;
                cycles_o     = (dst == REG_MEM) ? CYC_10 : CYC_7;
                cycles_alt_o = cycles_o;
            end
            8'b00??_?10?:
            begin
                op_class_o   = src[0] ? CLS_DECREMENT_REG
                                      : CLS_INCREMENT_REG;
                cycles_o     = (dst == REG_MEM) ? CYC_10 : CYC_5;
                cycles_alt_o = cycles_o;
            end
            8'b10??_????:
            begin
                op_class_o   = CLS_ALU_ACCUMULATOR;
                cycles_o     = (src == REG_MEM) ? CYC_7 : CYC_4;
                cycles_alt_o = cycles_o;
            end
            8'b11??_?110:
            begin
                op_class_o   = CLS_ALU_IMMEDIATE;
                length_o     = 2'd2;
                cycles_o     = CYC_7;
                cycles_alt_o = CYC_7;
            end
            8'b11??_?000:
            begin
                op_class_o   = CLS_COND_RETURN;
                cycles_o     = CYC_5;
                cycles_alt_o = CYC_11;
            end
            8'b0000_0001, 8'b0001_0001, 8'b0010_0001, 8'b0011_0001:
            begin
                op_class_o   = CLS_LOAD_PAIR_IMM;
                length_o     = 2'd3;
                cycles_o     = CYC_10;
                cycles_alt_o = CYC_10;
            end
            8'b1100_0101, 8'b1101_0101, 8'b1110_0101, 8'b1111_0101:
            begin
                op_class_o   = CLS_PUSH_PAIR;
                cycles_o     = CYC_11;
                cycles_alt_o = CYC_11;
            end
            8'b11??_?010, 8'b1100_0011, 8'b11??_?100,
            8'b1100_1101, 8'b0011_?010, 8'b0010_?010:
            begin
                op_class_o = CLS_JUMP_CALL_DIRECT;
                length_o   = 2'd3;
                cycles_o   = CYC_10;
                cycles_alt_o = CYC_10;
            end
            8'b1101_?011:
            begin
                op_class_o   = CLS_IO;
                length_o     = 2'd2;
                cycles_o     = CYC_10;
                cycles_alt_o = CYC_10;
            end
            default:
            begin
                op_class_o = CLS_OTHER_ONE_BYTE;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- src/cpu_opcode_decoder.sv
// Purpose: Fetch-side instruction decoder for an 8-bit processor
// Assumes: Program memory presents one byte per valid strobe
// Notes:   Decoded fields stay valid until the next opcode
`timescale 1ns/100ps
`default_nettype none
module cpu_opcode_decoder
    import opdec_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    input  wire logic [BYTE_W-1:0] fetch_byte_i,
    input  wire logic              fetch_valid_i,
    output logic                   fetch_ready_o,
    output logic                   fetch_next_addr_o,
    output logic                   instr_valid_o,
    output logic [BYTE_W-1:0]      opcode_o,
    output logic [BYTE_W-1:0]      operand_lo_o,
    output logic [BYTE_W-1:0]      operand_hi_o,
    output logic [1:0]             length_o,
    output logic [3:0]             op_class_o,
    output logic [4:0]             cycles_o,
    output logic [4:0]             cycles_alt_o,
    output logic [2:0]             dest_reg_field_o,
    output logic [2:0]             src_reg_field_o,
    output logic [1:0]             pair_o,
    output logic                   halt_instr_o
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        fetch_st_t   st;
        logic        valid;
        logic [7:0]  opcode;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [1:0]  len;
        op_class_t   cls;
        logic [4:0]  cyc;
        logic [4:0]  cyc_alt;
        logic [2:0]  dst;
        logic [2:0]  src;
        logic [1:0]  pair;
    } dec_state_t;

    dec_state_t s_q;
    dec_state_t s_d;

    op_class_t  c_cls;
    logic [1:0] c_len;
    logic [4:0] c_cyc;
    logic [4:0] c_cyc_alt;
    logic [2:0] c_dst;
    logic [2:0] c_src;
    logic [1:0] c_pair;

    opcode_classifier u_classifier (
        .opcode_i         (fetch_byte_i),
        .op_class_o       (c_cls),
        .length_o         (c_len),
        .cycles_o         (c_cyc),
        .cycles_alt_o     (c_cyc_alt),
        .dest_reg_field_o (c_dst),
        .src_reg_field_o  (c_src),
        .pair_o           (c_pair)
    );

    always_comb
    begin
        s_d       = s_q;
        s_d.valid = 1'b0;
        unique case (s_q.st)
            ST_OPCODE:
            begin
                if (fetch_valid_i)
                begin
                    s_d.opcode  = fetch_byte_i;
                    s_d.lo      = RST_BYTE;
                    s_d.hi      = RST_BYTE;
                    s_d.len     = c_len;
                    s_d.cls     = c_cls;
                    s_d.cyc     = c_cyc;
                    s_d.cyc_alt = c_cyc_alt;
                    s_d.dst     = c_dst;
                    s_d.src     = c_src;
                    s_d.pair    = c_pair;
                    if (c_len == 2'd1)
                        s_d.valid = 1'b1;
                    else
                        s_d.st = ST_BYTE2;
                end
            end
            ST_BYTE2:
            begin
                if (fetch_valid_i)
                begin
                    s_d.lo = fetch_byte_i;
                    if (s_q.len == 2'd3)
                        s_d.st = ST_BYTE3;
                    else
                    begin
                        s_d.st    = ST_OPCODE;
                        s_d.valid = 1'b1;
                    end
                end
            end
            ST_BYTE3:
            begin
                if (fetch_valid_i)
                begin
                    s_d.hi    = fetch_byte_i;
                    s_d.st    = ST_OPCODE;
                    s_d.valid = 1'b1;
                end
            end
            default:
            begin
                s_d.st = ST_OPCODE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.st      <= ST_OPCODE;
            s_q.valid   <= 1'b0;
            s_q.opcode  <= RST_BYTE;
            s_q.lo      <= RST_BYTE;
            s_q.hi      <= RST_BYTE;
            s_q.len     <= RST_COUNT;
            s_q.cls     <= CLS_UNKNOWN;
            s_q.cyc     <= 5'h00;
            s_q.cyc_alt <= 5'h00;
            s_q.dst     <= REG_B;
            s_q.src     <= REG_B;
            s_q.pair    <= PAIR_BC;
        end
        else
            s_q <= s_d;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign fetch_ready_o     = rst_n;
    assign fetch_next_addr_o = rst_n & fetch_valid_i;
    assign instr_valid_o     = s_q.valid;
    assign opcode_o          = s_q.opcode;
    assign operand_lo_o      = s_q.lo;
    assign operand_hi_o      = s_q.hi;
    assign length_o          = s_q.len;
    assign op_class_o        = s_q.cls;
    assign cycles_o          = s_q.cyc;
    assign cycles_alt_o      = s_q.cyc_alt;
    assign dest_reg_field_o  = s_q.dst;
    assign src_reg_field_o   = s_q.src;
    assign pair_o            = s_q.pair;
    assign halt_instr_o      = (s_q.cls == CLS_HALT_INSTR);
endmodule
`default_nettype wire

//--- bench/cpu_opcode_decoder_properties.sv
// Purpose: Port-level assertions for the opcode decoder
// Assumes: Ready rises two edges after reset release
// Notes:   Byte position is tracked from the take strobe
`timescale 1ns/100ps
`default_nettype none
module cpu_opcode_decoder_properties
    import opdec_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    input wire logic [7:0] fetch_byte_i,
    input wire logic       fetch_valid_i,
    input wire logic       fetch_ready_o,
    input wire logic       fetch_next_addr_o,
    input wire logic       instr_valid_o,
    input wire logic [7:0] opcode_o,
    input wire logic [7:0] operand_lo_o,
    input wire logic [7:0] operand_hi_o,
    input wire logic [1:0] length_o,
    input wire logic [3:0] op_class_o,
    input wire logic [4:0] cycles_o,
    input wire logic [4:0] cycles_alt_o,
    input wire logic [2:0] dest_reg_field_o,
    input wire logic [2:0] src_reg_field_o,
    input wire logic       halt_instr_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // ----
    // Byte position
    // ----
    // Takes so far in this instruction; restarts on done
    logic [1:0] cnt_q;
    logic       tk;
    logic       op_tk;
    assign tk    = fetch_next_addr_o;
    assign op_tk = tk && (instr_valid_o || cnt_q == 2'h0);
    always_ff @(posedge mclk_i or negedge reset_n_i)
        if (!reset_n_i)
            cnt_q <= 2'h0;
        else
            cnt_q <= (instr_valid_o ? 2'h0 : cnt_q) + {1'b0, tk};
    sequence s_ready_up;
        !fetch_ready_o ##1 !fetch_ready_o ##1 fetch_ready_o;
    endsequence
    sequence s_lo_tk;
        tk && !instr_valid_o && cnt_q == 2'h1;
    endsequence
    sequence s_hi_tk;
        tk && !instr_valid_o && cnt_q == 2'h2;
    endsequence
    // ----
    // Assertions
    // ----
    a_ready_release: assert property (
        $rose(reset_n_i) |-> s_ready_up)
        else $error("ready rose at the wrong edge");
    a_take_strobe: assert property (
        tk == (fetch_valid_i && fetch_ready_o))
        else $error("take strobe mismatch");
    a_done_after_take: assert property (
        instr_valid_o |-> $past(tk))
        else $error("done without a byte taken");
    a_length_takes: assert property (
        instr_valid_o |-> cnt_q == length_o)
        else $error("byte count differs from length");
    a_opcode_fields: assert property (
        op_tk |=> opcode_o == $past(fetch_byte_i)
            && dest_reg_field_o == opcode_o[5:3]
            && src_reg_field_o == opcode_o[2:0])
        else $error("opcode fields wrong");
    a_low_byte: assert property (
        s_lo_tk |=> operand_lo_o == $past(fetch_byte_i))
        else $error("second byte not in low operand");
    a_high_byte: assert property (
        s_hi_tk |=> operand_hi_o == $past(fetch_byte_i))
        else $error("third byte not in high operand");
    a_halt_level: assert property (
        halt_instr_o == (op_class_o == CLS_HALT_INSTR))
        else $error("halt flag mismatch");
    a_cond_cycles: assert property (
        op_class_o == CLS_COND_RETURN
            |-> cycles_o == CYC_5 && cycles_alt_o == CYC_11)
        else $error("return cycle counts wrong");
    a_copy_cycles: assert property (
        instr_valid_o && op_class_o == CLS_COPY_REGISTER
            |-> cycles_o == ((dest_reg_field_o == REG_MEM
            || src_reg_field_o == REG_MEM) ? CYC_7 : CYC_5))
        else $error("copy cycle count wrong");
    a_alu_cycles: assert property (
        instr_valid_o && op_class_o == CLS_ALU_ACCUMULATOR
            |-> cycles_o == (src_reg_field_o == REG_MEM ? CYC_7 : CYC_4))
        else $error("accumulator cycle count wrong");
endmodule
`default_nettype wire

//--- bench/prog_memory_model.sv
// Purpose: Program memory feeding the decoder in address order
// Assumes: One byte consumed per edge with take high
// Notes:   Idle byte lines invert their previous value every cycle
`timescale 1ns/100ps
`default_nettype none
module prog_memory_model
(
    input  wire logic       mclk_i,
    input  wire logic       take_i,
    input  wire logic [6:0] end_i,
    input  wire logic       slow_i,
    output logic [7:0]      byte_o,
    output logic            valid_o
);
    logic [7:0] mem [0:127];
    logic [6:0] addr_q = 7'h00;
    logic [6:0] nxt;
    logic       on;
    initial
    begin
        byte_o  = 8'h00;
        valid_o = 1'b0;
    end
    // ----
    // Byte stream
    // ----
    // next byte from next address
    always @(posedge mclk_i)
    begin
        nxt = addr_q + {6'h00, take_i};
        // Slow mode idles one cycle after each byte
        on = nxt < end_i && !(slow_i && take_i);
        addr_q  <= nxt;
        valid_o <= #1 on;
        byte_o  <= #1 on ? mem[nxt] : ~byte_o;
    end
endmodule
`default_nettype wire

//--- bench/tb_cpu_opcode_decoder.sv
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Decoder always accepts once out of reset
// Notes:   Table runs back-to-back, then with idle gaps
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("Error at %0t: got %h exp %h", $time, got, exp); \
        end \
    end
module tb_cpu_opcode_decoder;
    import opdec_pkg::*;
    logic        mclk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [7:0]  fetch_byte_i, opcode_o, operand_lo_o, operand_hi_o, lo, hi;
    logic        fetch_valid_i, fetch_ready_o, fetch_next_addr_o;
    logic        instr_valid_o, halt_instr_o;
    logic [1:0]  length_o, pair_o;
    logic [3:0]  op_class_o;
    logic [4:0]  cycles_o, cycles_alt_o;
    logic [2:0]  dest_reg_field_o, src_reg_field_o;
    logic [6:0]  end_q = 7'h00;
    logic        slow_q = 1'b0;
    logic [31:0] r;
    int          fails = 0, comparisons = 0, idx = 0, k;
    logic [31:0] rows [32] = '{
        32'h4111_0505, 32'h7E11_0707, 32'h7011_0707, 32'h7612_0707,
        32'h0623_0707, 32'h3623_0A0A, 32'h3C14_0505, 32'h3515_0A0A,
        32'h8016_0404, 32'h8916_0404, 32'h9216_0404, 32'h9B16_0404,
        32'hA416_0404, 32'hAD16_0404, 32'hB616_0707, 32'hBF16_0404,
        32'hBE16_0707, 32'hC018_050B, 32'hC818_050B, 32'hE018_050B,
        32'hE818_050B, 32'hF018_050B, 32'hF818_050B, 32'h0139_0A0A,
        32'h1139_0A0A, 32'h2139_0A0A, 32'h3139_0A0A, 32'hC51A_0B0B,
        32'hC33B_0A0A, 32'hFE27_0707, 32'hDB2C_0A0A, 32'h071D_0404};
    always #12.5 mclk_i = ~mclk_i;
    cpu_opcode_decoder dut_u (.mclk_i, .reset_n_i, .fetch_byte_i,
        .fetch_valid_i, .fetch_ready_o, .fetch_next_addr_o, .instr_valid_o,
        .opcode_o, .operand_lo_o, .operand_hi_o, .length_o, .op_class_o,
        .cycles_o, .cycles_alt_o, .dest_reg_field_o, .src_reg_field_o,
        .pair_o, .halt_instr_o);
    prog_memory_model mem_u (.mclk_i, .take_i(fetch_next_addr_o),
        .end_i(end_q), .slow_i(slow_q), .byte_o(fetch_byte_i),
        .valid_o(fetch_valid_i));
    task automatic load(input int b);
        for (int j = 0; j < 32; j++)
        begin
            mem_u.mem[b++] = rows[j][31:24];
            if (rows[j][21:20] > 2'h1) mem_u.mem[b++] = 8'hA0 + 8'(j);
            if (rows[j][21:20] > 2'h2) mem_u.mem[b++] = 8'h50 + 8'(j);
        end
    endtask
    task automatic wait_idx(input int n);
        repeat (400)
            if (idx < n) @(posedge mclk_i);
    endtask
    task tally_and_finish();
        if (fails == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ----
    // Completed-instruction monitor
    // ----
    always @(negedge mclk_i)
        if (instr_valid_o === 1'b1)
        begin
            k = idx % 32;
            r = rows[k];
            idx++;
            lo = r[21:20] > 2'h1 ? 8'hA0 + 8'(k) : 8'h00;
            hi = r[21:20] > 2'h2 ? 8'h50 + 8'(k) : 8'h00;
            `CHK({length_o, op_class_o}, r[21:16])
            `CHK({cycles_o, cycles_alt_o}, {r[12:8], r[4:0]})
            `CHK(opcode_o, r[31:24])
            `CHK({operand_lo_o, operand_hi_o}, {lo, hi})
            `CHK({dest_reg_field_o, src_reg_field_o}, r[29:24])
            `CHK(pair_o, r[29:28])
            `CHK(halt_instr_o, r[31:24] == OPC_HALT)
        end
    initial
    begin
        load(0);
        load(46);
        repeat (10) @(posedge mclk_i);
        @(negedge mclk_i);
        `CHK({fetch_ready_o, instr_valid_o, op_class_o}, 6'h00)
        @(posedge mclk_i) #1 reset_n_i = 1'b1;
        end_q = 7'h2E;
        wait_idx(32);
        `CHK(idx, 32)
        @(posedge mclk_i) #1 slow_q = 1'b1;
        end_q = 7'h5C;
        wait_idx(64);
        `CHK(idx, 64)
        // Reset in mid-jump must drop the partial instruction
        mem_u.mem[92] = 8'hC3;
        @(posedge mclk_i) #1 slow_q = 1'b0;
        end_q = 7'h5D;
        repeat (4) @(posedge mclk_i);
        #1;
        `CHK(length_o, 2'h3)
        reset_n_i = 1'b0;
        @(negedge mclk_i);
        `CHK({opcode_o, length_o, fetch_ready_o}, 11'h000)
        @(posedge mclk_i) #1 reset_n_i = 1'b1;
        mem_u.mem[93] = 8'h41;
        end_q = 7'h5E;
        wait_idx(65);
        `CHK(idx, 65)
        tally_and_finish();
    end
    initial
    begin
        #20000;
        fails++;
        tally_and_finish();
    end
endmodule
bind cpu_opcode_decoder cpu_opcode_decoder_properties prop_u (.mclk_i,
    .reset_n_i, .fetch_byte_i, .fetch_valid_i, .fetch_ready_o,
    .fetch_next_addr_o, .instr_valid_o, .opcode_o, .operand_lo_o,
    .operand_hi_o, .length_o, .op_class_o, .cycles_o, .cycles_alt_o,
    .dest_reg_field_o, .src_reg_field_o, .halt_instr_o);
`default_nettype wire
